// *** rtl/strap_cfg_consts.svh ***
`ifndef STRAP_CFG_CONSTS_SVH
`define STRAP_CFG_CONSTS_SVH
`define CYC_INDEX 6'h10
`define HPC_INDEX 6'h2A
`define HI_WORD_OFS 8'h04
`define CYC_LO_ADDR {`CYC_INDEX, 2'b00}
`define CYC_HI_ADDR ({`CYC_INDEX, 2'b00} + `HI_WORD_OFS)
`define HPC_LO_ADDR {`HPC_INDEX, 2'b00}
`define HPC_HI_ADDR ({`HPC_INDEX, 2'b00} + `HI_WORD_OFS)
`define MODEL_ADDR 8'h00
`define BIT_TRI 0
`define BIT_BIST 1
`define BIT_IOQ 2
`define BIT_MCE 3
`define BIT_BUS_INIT_SIGNAL 4
`define BIT_CLU_LO 5
`define BIT_CLU_HI 6
`define BIT_PARK 7
`define BIT_AGT_LO 12
`define BIT_AGT_HI 13
`define HPC_RSV_MASK 32'hFFFF_CF00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** rtl/strap_cfg_pkg.sv ***
package strap_cfg_pkg;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } rd_state_t;
endpackage

// *** rtl/strap_capture.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "strap_cfg_consts.svh"
module strap_capture (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [13:0] strap_i,
  output logic [63:0] cfg_o
);
  localparam logic [13:0] RSV_LOW = 14'(`HPC_RSV_MASK);
  logic rst_q;
  // ==========================================
  // capture on reset release, cleared while in reset
  always_ff @(posedge clk_sys_i) begin
    rst_q <= rst_i;
    if (rst_i) begin
      cfg_o <= 64'h0;
    end else if (rst_q) begin
      cfg_o <= {50'h0, strap_i & ~RSV_LOW};
    end
  end
endmodule
`default_nettype wire

// *** rtl/strap_config_and_cycle_counter_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "strap_cfg_consts.svh"
module strap_config_and_cycle_counter_regs
  import strap_cfg_pkg::*;
#(
  parameter logic LATER_MODEL = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic mgmt_interrupt_strap_pin_i,
  input wire logic init_strap_pin_i,
  input wire logic addr_strap_seven_i,
  input wire logic addr_strap_nine_i,
  input wire logic addr_strap_ten_i,
  input wire logic addr_strap_eleven_i,
  input wire logic addr_strap_twelve_i,
  input wire logic addr_strap_fifteen_i,
  input wire logic [1:0] bus_request_straps_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [13:0] strap;
  logic [63:0] hpc;
  logic [63:0] cycle_count;
  logic later_model;
  logic [7:0] aw_addr;
  logic aw_have;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_have;
  logic wr_fire;
  rd_state_t rd_state;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    if (a == `CYC_LO_ADDR || a == `CYC_HI_ADDR) begin
      hit = 1'b1;
    end else if (a == `HPC_LO_ADDR || a == `HPC_HI_ADDR) begin
      hit = 1'b1;
    end else if (a == `MODEL_ADDR) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
    return hit;
  endfunction

  // ==========================================
  // strap capture
  always_comb begin
    strap = '0;
    strap[`BIT_TRI] = mgmt_interrupt_strap_pin_i;
    strap[`BIT_BIST] = init_strap_pin_i;
    strap[`BIT_IOQ] = addr_strap_seven_i;
    strap[`BIT_MCE] = addr_strap_nine_i;
    strap[`BIT_BUS_INIT_SIGNAL] = addr_strap_ten_i;
    strap[`BIT_CLU_LO] = addr_strap_eleven_i;
    strap[`BIT_CLU_HI] = addr_strap_twelve_i;
    strap[`BIT_PARK] = addr_strap_fifteen_i;
    strap[`BIT_AGT_HI:`BIT_AGT_LO] = bus_request_straps_i;
  end

  strap_capture u_cap (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .strap_i(strap),
    .cfg_o(hpc)
  );

  // ==========================================
  // model select, loaded from LATER_MODEL at reset, then set by writes to MODEL_ADDR
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      later_model <= LATER_MODEL;
    end else if (wr_fire && aw_addr == `MODEL_ADDR && w_strb[0]) begin
      later_model <= w_data[0];
    end
  end

  // ==========================================
  // write channel
  assign wr_fire = aw_have && w_have && !s_axi_bvalid;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_have && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (is_mapped(aw_addr)) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================
  // cycle counter
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cycle_count <= 64'h0;
    end else if (wr_fire && aw_addr == `CYC_LO_ADDR) begin
      if (later_model) begin
        cycle_count <= {cycle_count[63:32], merge(cycle_count[31:0], w_data, w_strb)};
      end else begin
        cycle_count <= {32'h0, merge(cycle_count[31:0], w_data, w_strb)};
      end
    end else if (wr_fire && aw_addr == `CYC_HI_ADDR && later_model) begin
      cycle_count <= {merge(cycle_count[63:32], w_data, w_strb), cycle_count[31:0]};
    end else begin
      cycle_count <= cycle_count + 64'h1;
    end
  end

  // ==========================================
  // read channel, hpc writes ignored
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_state <= RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
          if (s_axi_arvalid && s_axi_arready) begin
            rd_state <= RD_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            if (s_axi_araddr == `CYC_LO_ADDR) begin
              s_axi_rdata <= cycle_count[31:0];
            end else if (s_axi_araddr == `CYC_HI_ADDR) begin
              s_axi_rdata <= cycle_count[63:32];
            end else if (s_axi_araddr == `HPC_LO_ADDR) begin
              s_axi_rdata <= hpc[31:0] & ~`HPC_RSV_MASK;
            end else if (s_axi_araddr == `HPC_HI_ADDR) begin
              s_axi_rdata <= 32'h0;
            end else if (s_axi_araddr == `MODEL_ADDR) begin
              s_axi_rdata <= {31'h0, later_model};
            end else begin
              s_axi_rdata <= 32'h0;
              s_axi_rresp <= `RESP_SLVERR;
            end
          end
        end
        RD_RESP: begin
          s_axi_arready <= 1'b0;
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state <= RD_IDLE;
          end
        end
        default: begin
          rd_state <= RD_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // checks
  sequence lo_write_s;
    wr_fire && aw_addr == `CYC_LO_ADDR && w_strb == 4'hF;
  endsequence

  sequence hi_write_s;
    wr_fire && aw_addr == `CYC_HI_ADDR;
  endsequence

  sequence hpc_write_s;
    wr_fire && (aw_addr == `HPC_LO_ADDR || aw_addr == `HPC_HI_ADDR);
  endsequence

  sequence ar_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence

  sequence rd_answer_s;
    s_axi_rvalid && s_axi_rresp == `RESP_OKAY;
  endsequence

  // ==========================================
  // counter checks
  early_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    lo_write_s and !later_model |=> cycle_count[63:32] == 32'h0)
    else $error("upper counter not cleared");
  early_lo_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    lo_write_s and !later_model |=> cycle_count[31:0] == $past(w_data))
    else $error("lower counter not written");
  early_hi_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    hi_write_s and !later_model |=> cycle_count == $past(cycle_count) + 64'h1)
    else $error("upper counter written on early model");
  later_lo_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    lo_write_s and later_model |=> cycle_count[63:32] == $past(cycle_count[63:32]))
    else $error("upper counter disturbed");
  later_lo_val_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    lo_write_s and later_model |=> cycle_count[31:0] == $past(w_data))
    else $error("lower counter not written");
  later_hi_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    hi_write_s and later_model && w_strb == 4'hF |=>
      cycle_count[63:32] == $past(w_data) && cycle_count[31:0] == $past(cycle_count[31:0]))
    else $error("upper counter not written");
  count_run_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !(wr_fire && (aw_addr == `CYC_LO_ADDR || (aw_addr == `CYC_HI_ADDR && later_model))) |=>
      cycle_count == $past(cycle_count) + 64'h1)
    else $error("counter did not advance");

  // ==========================================
  // config checks
  hpc_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !$fell(rst_i) |=> $stable(hpc))
    else $error("config changed without reset");
  hpc_wr_ign_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    hpc_write_s |=> $stable(hpc))
    else $error("config changed by write");
  hpc_rsv_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (hpc[31:0] & `HPC_RSV_MASK) == 32'h0 && hpc[63:32] == 32'h0)
    else $error("reserved config bit set");
  hpc_read_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ar_take_s and s_axi_araddr == `HPC_LO_ADDR |=> rd_answer_s and
      s_axi_rdata[`BIT_PARK:`BIT_TRI] == hpc[`BIT_PARK:`BIT_TRI] &&
      s_axi_rdata[`BIT_AGT_HI:`BIT_AGT_LO] == hpc[`BIT_AGT_HI:`BIT_AGT_LO] &&
      (s_axi_rdata & `HPC_RSV_MASK) == 32'h0)
    else $error("config read mismatch");
  hpc_hi_read_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ar_take_s and s_axi_araddr == `HPC_HI_ADDR |=> rd_answer_s and s_axi_rdata == 32'h0)
    else $error("upper config word not zero");
  hpc_cap_a: assert property (@(posedge clk_sys_i)
    $fell(rst_i) |=> hpc[`BIT_PARK:`BIT_TRI] == $past(strap[`BIT_PARK:`BIT_TRI]) &&
      hpc[`BIT_AGT_HI:`BIT_AGT_LO] == $past(bus_request_straps_i))
    else $error("straps not captured");

  for (genvar b = `BIT_TRI; b <= `BIT_PARK; b++) begin : g_bit_chk
    bit_cap_a: assert property (@(posedge clk_sys_i)
      $fell(rst_i) |=> hpc[b] == $past(strap[b]))
      else $error("strap bit not captured");
  end

  // ==========================================
  // bus checks
  wr_answer_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_fire |=> s_axi_bvalid)
    else $error("write not answered");
  rd_answer_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ar_take_s |=> s_axi_rvalid)
    else $error("read not answered");
  wr_block_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  rd_block_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "strap_cfg_consts.svh"
module testbench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] strap = 10'h000;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_val, cfg_exp;
  logic [1:0] rd_resp;
  logic [1:0] exp_bresp = `RESP_OKAY;
  int miscompares = 0;
  int compares = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  strap_config_and_cycle_counter_regs strap_config_and_cycle_counter_regs_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .mgmt_interrupt_strap_pin_i(strap[0]), .init_strap_pin_i(strap[1]),
    .addr_strap_seven_i(strap[2]), .addr_strap_nine_i(strap[3]),
    .addr_strap_ten_i(strap[4]), .addr_strap_eleven_i(strap[5]),
    .addr_strap_twelve_i(strap[6]), .addr_strap_fifteen_i(strap[7]),
    .bus_request_straps_i(strap[9:8]),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  // ==========================================
  // bus, check, reset and report tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys_i);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys_i);
    check({30'h0, s_axi_bresp}, {30'h0, exp_bresp});
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk_sys_i);
    rd_val = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic do_reset(input logic [9:0] s);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    strap <= s;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    strap <= ~s;
    cfg_exp = {18'h0, s[9:8], 4'h0, s[7:0]};
  endtask
  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // watchdog
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    miscompares++;
    report_and_stop();
  end
  // ==========================================
  // tests
  initial begin
    for (int p = 0; p < 2; p++) begin
      do_reset(p == 0 ? 10'h2B5 : 10'h14A);
      axi_rd(`HPC_LO_ADDR);
      check(rd_val, cfg_exp);
      axi_wr(`HPC_LO_ADDR, 32'hFFFF_FFFF);
      axi_wr(`HPC_HI_ADDR, 32'hFFFF_FFFF);
      axi_rd(`HPC_LO_ADDR);
      check(rd_val, cfg_exp);
      axi_rd(`HPC_HI_ADDR);
      check(rd_val, 32'h0000_0000);
    end
    axi_wr(`MODEL_ADDR, 32'h0000_0001);
    axi_wr(`CYC_HI_ADDR, 32'h0000_0005);
    axi_wr(`CYC_LO_ADDR, 32'h0000_1000);
    axi_rd(`CYC_LO_ADDR);
    check({31'h0, (rd_val - 32'h0000_1000) < 32'h0000_0020}, 32'h0000_0001);
    axi_rd(`CYC_HI_ADDR);
    check(rd_val, 32'h0000_0005);
    axi_wr(`MODEL_ADDR, 32'h0000_0000);
    axi_wr(`CYC_HI_ADDR, 32'h0000_0077);
    axi_rd(`CYC_HI_ADDR);
    check(rd_val, 32'h0000_0005);
    axi_wr(`CYC_LO_ADDR, 32'h0000_0200);
    axi_rd(`CYC_HI_ADDR);
    check(rd_val, 32'h0000_0000);
    axi_rd(`CYC_LO_ADDR);
    check({31'h0, (rd_val - 32'h0000_0200) < 32'h0000_0020}, 32'h0000_0001);
    axi_rd(8'h80);
    check(rd_val, 32'h0000_0000);
    check({30'h0, rd_resp}, {30'h0, `RESP_SLVERR});
    exp_bresp = `RESP_SLVERR;
    axi_wr(8'h80, 32'hFFFF_FFFF);
    exp_bresp = `RESP_OKAY;
    axi_rd(`HPC_LO_ADDR);
    check(rd_val, cfg_exp);
    report_and_stop();
  end
endmodule
`default_nettype wire
